// [inc/mode_word_map.svh]
// offsets, field positions, reset values and data bit numbers of the mode word decoder
`ifndef MODE_WORD_MAP_SVH
`define MODE_WORD_MAP_SVH

// register byte addresses
`define MW_CTRL_ADDR 8'h00
`define MW_STATUS_ADDR 8'h04
`define MW_WORD_ADDR 8'h08

// control register fields
`define MW_CTRL_QUERY 0
`define MW_CTRL_REMOTE 1
`define MW_CTRL_RECALL 2
`define MW_CTRL_RESET 32'h0000_0000

// status register fields
`define MW_ST_POWER 0
`define MW_ST_DRIVE_LO 4
`define MW_ST_OSH_LO 8
`define MW_ST_FILL_LO 12
`define MW_ST_SUPPLY 16

// data bit numbering: shift register index = data bit - base
`define MW_DATA_BIT_BASE 16
`define MW_RESET_BIT 18
`define MW_POWER_BIT 36
`define MW_LATCH_LO 8
`define MW_IDENT_VALUE 4'h3

// fields inside the latched section
`define MW_DRIVE_LO 0
`define MW_OSH_LO 3

`define MW_POWER_RESET 1'b1

`endif

// [inc/mode_word_pkg.sv]
// types shared by the mode word decoder
package mode_word_pkg;

   typedef enum logic [1:0] {
      SRC_AUX,
      SRC_REVERTIVE,
      SRC_HIGHWAY,
      SRC_RECALL
   } source_type;

   typedef struct packed {
      logic reset_req;
      logic power_level;
      logic power_load;
      logic state_load;
      logic [2:0] drive_state;
      logic [2:0] osh_state;
   } mode_record_type;

   typedef struct packed {
      logic aux_n;
      logic revertive_n;
      logic highway_n;
      logic recall_n;
   } serial_in_type;

endpackage : mode_word_pkg

// [hw/mode_word_input_decoder.sv]
// receive-side mode word decoder with wishbone registers and output buffer
//
// The Wishbone register port and the register offsets were left to the implementer.
`include "mode_word_map.svh"

// Overview of operation
// R1 - pick data source from status selection
// R2 - shift selected data into 32-bit register
// R3 - mode circuits capture only on ident pulse
// R4 - latched section copies shift stages every cycle
// R5 - latched outputs driven only while enabled
// R6 - ident pulse when ident matches at strobe
// R7 - ident pulse enables latched section outputs
// R8 - reset bit passes ident pulse to reset
// R9 - query or remote-in allows mode loading
// R10 - recall or aux source blocks mode updates
// R11 - supply fail blocks drive and standby updates
// R12 - power level loaded from data bit 36
// R13 - all logic synchronous, strobes one cycle
module mode_word_input_decoder #(
   parameter int unsigned FIFO_DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // serial display data, inverted, one line per source
   input wire mode_word_pkg::serial_in_type serial_i,
   input wire logic shift_strobe_i,
   output logic shift_ready_o,
   input wire logic display_strobe_i,
   input wire logic supply_fail_i,
   // storage-latch section parallel outputs
   output logic [7:0] latch_q_o,
   output logic latch_oe_n_o,
   output logic reset_pulse_o,
   output logic power_level_o,
   output logic [2:0] drive_state_o,
   output logic [2:0] osh_state_o,
   // buffered mode records towards the receiver
   output mode_word_pkg::mode_record_type mode_o,
   output logic mode_valid_o,
   input wire logic mode_ready_i
);

   localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);

   function automatic int unsigned data_index(input int unsigned bit_num);
      return bit_num - `MW_DATA_BIT_BASE;
   endfunction : data_index

   logic [31:0] ctrl;
   logic [31:0] input_shift;
   logic [3:0] ident_field_register;
   logic [7:0] latched_shift_section;
   logic power_level_flop;
   logic [2:0] drive_state;
   logic [2:0] osh_state;
   mode_word_pkg::mode_record_type fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] fill;

   // source selection
   wire logic query_sel = ctrl[`MW_CTRL_QUERY];
   wire logic remote_sel = ctrl[`MW_CTRL_REMOTE];
   wire logic recall_sel = ctrl[`MW_CTRL_RECALL];
   mode_word_pkg::source_type source;
   // recall takes priority because the button overrides any held status
   assign source = recall_sel ? mode_word_pkg::SRC_RECALL :      // [R1]
                   remote_sel ? mode_word_pkg::SRC_HIGHWAY :
                   query_sel ? mode_word_pkg::SRC_REVERTIVE :
                   mode_word_pkg::SRC_AUX;
   logic selected_n;
   always_comb begin
      unique case (source)
         mode_word_pkg::SRC_AUX: selected_n = serial_i.aux_n;
         mode_word_pkg::SRC_REVERTIVE: selected_n = serial_i.revertive_n;
         mode_word_pkg::SRC_HIGHWAY: selected_n = serial_i.highway_n;
         mode_word_pkg::SRC_RECALL: selected_n = serial_i.recall_n;
      endcase
   end
   wire logic serial_bit = ~selected_n;

   // buffer state and handshakes
   wire logic fifo_full = (fill == CNT_W'(FIFO_DEPTH));
   wire logic fifo_empty = (fill == '0);
   assign shift_ready_o = ~fifo_full;
   wire logic shift_take = shift_strobe_i & ~fifo_full;     // [R13]
   wire logic strobe_take = display_strobe_i & ~fifo_full;  // [R13]

   // ident detection and gating
   wire logic ident_match = (ident_field_register == `MW_IDENT_VALUE);
   wire logic ident_pulse = strobe_take & ident_match;               // [R6]
   wire logic status_qualify_gate = (query_sel | remote_sel) &
                                    ~recall_sel;                     // [R9] [R10]
   wire logic update_enable_gate = ident_pulse & status_qualify_gate; // [R9]
   wire logic state_enable = update_enable_gate & ~supply_fail_i;   // [R11]
   wire logic reset_bit = input_shift[data_index(`MW_RESET_BIT)];
   wire logic reset_bit_gate = ident_pulse & reset_bit;              // [R8]
   wire logic power_bit = input_shift[data_index(`MW_POWER_BIT)];
   wire logic [2:0] next_drive =
      latched_shift_section[`MW_DRIVE_LO +: 3];
   wire logic [2:0] next_osh = latched_shift_section[`MW_OSH_LO +: 3];
   wire logic push = ident_pulse;
   wire logic pop = mode_valid_o & mode_ready_i;

   mode_word_pkg::mode_record_type next_record;
   assign next_record = '{reset_req: reset_bit_gate,
                          power_level: power_bit,
                          power_load: update_enable_gate,
                          state_load: state_enable,
                          drive_state: next_drive,
                          osh_state: next_osh};

   // the latch copies what the stages take at this edge, as a transparent
   // latch would, so a strobe right after the last shift sees the new bits
   wire logic [31:0] next_shift = {input_shift[30:0], serial_bit};
   wire logic [31:0] stage_value = shift_take ? next_shift : input_shift;

   // shift chain: serial bit enters at index 0, ident field sits beyond bit 31
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_shift <= 32'h0000_0000;
         ident_field_register <= 4'h0;
      end else if (shift_take) begin
         input_shift <= next_shift;                                  // [R2]
         ident_field_register <= {ident_field_register[2:0],
                                  input_shift[31]};
      end
   end

   // storage latch strobe is tied high, so it follows the stages every clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latched_shift_section <= 8'h00;
      end else begin
         latched_shift_section <= stage_value[`MW_LATCH_LO +: 8];   // [R4]
      end
   end

   assign latch_q_o = latched_shift_section;
   // the enable follows the ident pulse; outside it the pins are released
   assign latch_oe_n_o = ~ident_pulse;                              // [R5] [R7]

   // mode circuits load only on a qualified ident pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_level_flop <= `MW_POWER_RESET;
         drive_state <= 3'h0;
         osh_state <= 3'h0;
      end else begin
         if (update_enable_gate) begin
            power_level_flop <= power_bit;                          // [R12] [R3]
         end
         if (state_enable) begin
            drive_state <= next_drive;                              // [R3]
            osh_state <= next_osh;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_pulse_o <= 1'b0;
      end else begin
         reset_pulse_o <= reset_bit_gate;                           // [R8]
      end
   end

   assign power_level_o = power_level_flop;
   assign drive_state_o = drive_state;
   assign osh_state_o = osh_state;

   // FIFO_DEPTH-entry record buffer (two by default); a full buffer stalls shifting and strobes
   always_ff @(posedge clk_i) begin
      if (push) begin
         fifo_mem[wr_ptr] <= next_record;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         fill <= fill + CNT_W'(push) - CNT_W'(pop);
      end
   end

   assign mode_valid_o = ~fifo_empty;
   assign mode_o = fifo_empty ? '0 : fifo_mem[rd_ptr];

   // wishbone slave: one wait state, ack drops after one cycle
   wire logic bus_req = cyc_i & stb_i & ~ack_o;
   wire logic hit_ctrl = (adr_i == `MW_CTRL_ADDR);
   wire logic hit_status = (adr_i == `MW_STATUS_ADDR);
   wire logic hit_word = (adr_i == `MW_WORD_ADDR);
   wire logic ctrl_write = bus_req & we_i & hit_ctrl;

   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`MW_ST_POWER] = power_level_flop;
      status_word[`MW_ST_DRIVE_LO +: 3] = drive_state;
      status_word[`MW_ST_OSH_LO +: 3] = osh_state;
      status_word[`MW_ST_FILL_LO +: CNT_W] = fill;
      status_word[`MW_ST_SUPPLY] = supply_fail_i;
   end

   logic [31:0] read_word;
   assign read_word = hit_ctrl ? ctrl :
                      hit_status ? status_word :
                      hit_word ? input_shift : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `MW_CTRL_RESET;
      end else if (ctrl_write) begin
         for (int i = 0; i < 4; i++) begin
            if (sel_i[i]) begin
               ctrl[i*8 +: 8] <= dat_i[i*8 +: 8] & ((i == 0) ? 8'h07 : 8'h00);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= (bus_req & ~we_i) ? read_word : 32'h0000_0000;
      end
   end

   // checks
   chk_ident_needs_match: assert property ( // [R6]
      @(posedge clk_i) disable iff (rst_i)
      ~latch_oe_n_o |-> ident_match && display_strobe_i)
      else $error("latch enabled without matching ident at strobe");

   chk_oe_follows_ident: assert property ( // [R7]
      @(posedge clk_i) disable iff (rst_i)
      (display_strobe_i && ident_match && !fifo_full) |-> !latch_oe_n_o)
      else $error("ident pulse did not enable latch outputs");

   chk_latch_tracks_shift: assert property ( // [R4] [R5]
      @(posedge clk_i) disable iff (rst_i)
      latch_q_o == input_shift[15:8])
      else $error("latched section not copying shift stages");

   chk_reset_pulse_cause: assert property ( // [R8]
      @(posedge clk_i) disable iff (rst_i)
      reset_pulse_o |-> $past(!latch_oe_n_o) && $past(input_shift[2]))
      else $error("reset pulse without ident and reset bit");

   chk_reset_bit_passes: assert property ( // [R8]
      @(posedge clk_i) disable iff (rst_i)
      (!latch_oe_n_o && input_shift[2]) |=> reset_pulse_o)
      else $error("reset bit set but no reset pulse");

   chk_power_loads_bit: assert property ( // [R12]
      @(posedge clk_i) disable iff (rst_i)
      (!latch_oe_n_o && (query_sel || remote_sel) && !recall_sel) |=>
      power_level_o == $past(input_shift[20]))
      else $error("power level not loaded from data bit 36");

   chk_state_loads_latch: assert property ( // [R3] [R11]
      @(posedge clk_i) disable iff (rst_i)
      (!latch_oe_n_o && (query_sel || remote_sel) && !recall_sel &&
       !supply_fail_i) |=>
      drive_state_o == $past(latch_q_o[2:0]) &&
      osh_state_o == $past(latch_q_o[5:3]))
      else $error("mode states not loaded from latched section");

   chk_recall_blocks_load: assert property ( // [R10]
      @(posedge clk_i) disable iff (rst_i)
      (recall_sel || !(query_sel || remote_sel)) |=>
      $stable(power_level_o) && $stable(drive_state_o))
      else $error("mode circuits updated under recall or aux source");

   chk_supply_fail_holds: assert property ( // [R11]
      @(posedge clk_i) disable iff (rst_i)
      supply_fail_i |=>
      $stable(drive_state_o) && $stable(osh_state_o))
      else $error("state changed while supply failed");

   chk_state_only_on_ident: assert property ( // [R3] [R9]
      @(posedge clk_i) disable iff (rst_i)
      latch_oe_n_o |=>
      $stable(drive_state_o) && $stable(osh_state_o) &&
      $stable(power_level_o))
      else $error("mode circuit changed without ident pulse");

   chk_shift_moves_in: assert property ( // [R2] [R1] [R13]
      @(posedge clk_i) disable iff (rst_i)
      (shift_strobe_i && shift_ready_o) |=>
      input_shift[0] == $past(~selected_n))
      else $error("selected bit not shifted in");

   chk_shift_holds_idle: assert property ( // [R2] [R13]
      @(posedge clk_i) disable iff (rst_i)
      !(shift_strobe_i && shift_ready_o) |=> $stable(input_shift))
      else $error("shift register moved without a taken strobe");

   chk_ident_field_fed: assert property ( // [R6]
      @(posedge clk_i) disable iff (rst_i)
      (shift_strobe_i && shift_ready_o) |=>
      ident_field_register ==
      {$past(ident_field_register[2:0]), $past(input_shift[31])})
      else $error("ident field not fed from the last shift stage");

   chk_recall_line_used: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      recall_sel |-> selected_n == serial_i.recall_n)
      else $error("recall selected but another line used");

   chk_remote_line_used: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (remote_sel && !recall_sel) |-> selected_n == serial_i.highway_n)
      else $error("remote-in selected but another line used");

   chk_query_line_used: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (query_sel && !remote_sel && !recall_sel) |->
      selected_n == serial_i.revertive_n)
      else $error("query selected but another line used");

   chk_aux_line_used: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (!query_sel && !remote_sel && !recall_sel) |->
      selected_n == serial_i.aux_n)
      else $error("no status held but aux line not used");

   chk_record_pushed: assert property ( // [R13]
      @(posedge clk_i) disable iff (rst_i)
      !latch_oe_n_o |=> mode_valid_o)
      else $error("ident pulse left no record in the buffer");

   chk_full_stalls: assert property ( // [R13]
      @(posedge clk_i) disable iff (rst_i)
      fifo_full |-> !shift_ready_o && latch_oe_n_o)
      else $error("full buffer did not stall the block");

endmodule : mode_word_input_decoder

// [bench/display_data_source.sv]
// far-side model: sends frames on one serial line, noise on the others
module display_data_source (
   input wire logic clk_i,
   input wire logic ready_i,
   output mode_word_pkg::serial_in_type serial_o,
   output logic shift_strobe_o,
   output logic display_strobe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] active = 2'h0;
   logic bit_now = 1'b0;
   logic noise = 1'b0;
   logic [3:0] lines;
   initial shift_strobe_o = 1'b0;
   initial display_strobe_o = 1'b0;
   always @(posedge clk_i) noise <= ~noise;
   // idle lines toggle so a wrong selection cannot match by luck
   always_comb begin
      lines = {noise, ~noise, noise, ~noise};
      lines[active] = ~bit_now;
   end
   assign serial_o = lines;
   // ident goes first, so the oldest bit ends in the ident field
   task automatic send(input logic [1:0] src, input logic [3:0] id,
                       input logic [31:0] word);
      logic [35:0] frame;
      frame = {id, word};
      @(posedge clk_i);
      active <= 2'h3 - src;
      for (int i = 35; i >= 0; i--) begin
         bit_now <= frame[i];
         shift_strobe_o <= 1'b1;
         do @(posedge clk_i); while (ready_i !== 1'b1);
      end
      shift_strobe_o <= 1'b0;
      display_strobe_o <= 1'b1;
      @(posedge clk_i);
      display_strobe_o <= 1'b0;
   endtask : send
endmodule : display_data_source

// [bench/tb_mode_word_input_decoder.sv]
// self-checking bench for the mode word input decoder
module tb_mode_word_input_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   // outs: reset pulse, power, drive, standby state
   typedef struct {
      logic [2:0] ctrl;
      logic [1:0] src;
      logic [31:0] word;
      logic fail;
      logic [7:0] latch;
      logic [7:0] outs;
   } row_type;
   row_type rows [6] = '{
      '{3'h0, 2'h0, 32'h0000_2d04, 1'b0, 8'h2d, 8'b1_1_000_000},
      '{3'h1, 2'h1, 32'h0000_2d04, 1'b0, 8'h2d, 8'b1_0_101_101},
      '{3'h2, 2'h2, 32'h0010_1a00, 1'b1, 8'h1a, 8'b0_1_101_101},
      '{3'h6, 2'h3, 32'h0000_3f04, 1'b0, 8'h3f, 8'b1_1_101_101},
      '{3'h2, 2'h2, 32'h0000_1a00, 1'b0, 8'h1a, 8'b0_0_010_011},
      '{3'h3, 2'h2, 32'h0010_0700, 1'b0, 8'h07, 8'b0_1_111_000}};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, supply_fail_i = 1'b0;
   logic ack_o, shift_ready_o, latch_oe_n_o, reset_pulse_o, power_level_o;
   logic mode_valid_o, mode_ready_i = 1'b1, shift_strobe_i, display_strobe_i;
   logic [7:0] adr_i = 8'h00, latch_q_o, latch_seen, got;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [2:0] drive_state_o, osh_state_o;
   mode_word_pkg::serial_in_type serial_i;
   mode_word_pkg::mode_record_type mode_o;
   int miscompares = 0, check_count = 0, cycles = 0;
   int oe_count = 0, reset_count = 0, rec_count = 0, n0, r0, c0;

   always #2.5 clk_i = ~clk_i;

   mode_word_input_decoder #(.FIFO_DEPTH(2)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .serial_i(serial_i),
      .shift_strobe_i(shift_strobe_i), .shift_ready_o(shift_ready_o),
      .display_strobe_i(display_strobe_i), .supply_fail_i(supply_fail_i),
      .latch_q_o(latch_q_o), .latch_oe_n_o(latch_oe_n_o),
      .reset_pulse_o(reset_pulse_o), .power_level_o(power_level_o),
      .drive_state_o(drive_state_o), .osh_state_o(osh_state_o),
      .mode_o(mode_o), .mode_valid_o(mode_valid_o),
      .mode_ready_i(mode_ready_i));

   display_data_source src (.clk_i(clk_i), .ready_i(shift_ready_o),
      .serial_o(serial_i), .shift_strobe_o(shift_strobe_i),
      .display_strobe_o(display_strobe_i));

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   // values read just after an edge are the ones sampled at that edge
   always @(posedge clk_i) begin
      cycles++;
      if (latch_oe_n_o === 1'b0) begin
         oe_count++;
         latch_seen = latch_q_o;
      end
      if (reset_pulse_o === 1'b1)
         reset_count++;
      if (mode_valid_o === 1'b1 && mode_ready_i === 1'b1)
         rec_count++;
      if (cycles == 6000) begin
         miscompares++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hf;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      if (n == 100)
         miscompares++;
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({power_level_o, drive_state_o, osh_state_o, mode_valid_o,
             shift_ready_o, latch_oe_n_o, reset_pulse_o, ack_o}, 12'h80c);
      wb(1'b0, 8'h00, 32'h0, rd);
      check(rd, 32'h0);
      $display("reset test done");
   endtask : do_reset

   initial begin
      do_reset();
      foreach (rows[i]) begin
         wb(1'b1, 8'h00, {29'h0, rows[i].ctrl}, rd);
         supply_fail_i <= rows[i].fail;
         n0 = oe_count;
         r0 = reset_count;
         src.send(rows[i].src, 4'h3, rows[i].word);
         repeat (3) @(posedge clk_i);
         check(oe_count - n0, 1);
         check(latch_seen, rows[i].latch);
         got = {1'(reset_count - r0), power_level_o, drive_state_o,
                osh_state_o};
         check(got, rows[i].outs);
         $display("row %0d done", i);
      end
      // wrong ident: no pulse, no state change
      wb(1'b1, 8'h00, 32'h1, rd);
      n0 = oe_count;
      src.send(2'h1, 4'h5, 32'h0000_2d04);
      repeat (3) @(posedge clk_i);
      check(oe_count - n0, 0);
      check({power_level_o, drive_state_o, osh_state_o}, 7'h78);
      $display("ident test done");
      // receiver stalls: buffer fills, source must hold, nothing lost
      mode_ready_i <= 1'b0;
      n0 = oe_count;
      c0 = rec_count;
      src.send(2'h1, 4'h3, 32'h0000_1a00);
      src.send(2'h1, 4'h3, 32'h0010_0700);
      @(posedge clk_i);
      check({mode_valid_o, shift_ready_o}, 2'b10);
      check(mode_o, 32'h0000_00d3);
      fork
         src.send(2'h1, 4'h3, 32'h0000_2d00);
         begin
            repeat (40) @(posedge clk_i);
            check(oe_count - n0, 2);
            mode_ready_i <= 1'b1;
         end
      join
      repeat (3) @(posedge clk_i);
      check(rec_count - c0, 3);
      check({latch_seen, power_level_o, drive_state_o, osh_state_o},
            15'h16ad);
      $display("buffer test done");
      wb(1'b1, 8'h00, 32'hffff_ffff, rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      check(rd, 32'h7);
      wb(1'b1, 8'h04, 32'hffff_ffff, rd);
      wb(1'b0, 8'h04, 32'h0, rd);
      check(rd, 32'h0000_0550);
      wb(1'b0, 8'h0c, 32'h0, rd);
      check(rd, 32'h0);
      $display("register test done");
      do_reset();
      summarize();
   end
endmodule : tb_mode_word_input_decoder
